// file: bench/board_model.sv
`timescale 1ns/10ps
module board_model (
  // Device pad side
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] pull_high_en,
  // Board sources
  input wire logic [31:0] src_val,
  input wire logic [31:0] src_en,
  output logic [31:0] pad_in
);
  // Undriven lines without pull-high show the inverse, not a settled value
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & src_en & src_val) | (~pad_oe & ~src_en & pull_high_en)
    | (~pad_oe & ~src_en & ~pull_high_en & ~pad_out);
endmodule // board_model

// file: bench/gpio_checker.sv
`timescale 1ns/10ps
module gpio_checker
  import gpio_pkg::*;
#(parameter logic [31:0] PULL_HIGH_OPT = 32'hFFFFFFFF) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Core access
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  input wire gpio_pkg::bit_op_t mem_op,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic mem_hit,
  // Pads
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] pull_high_en
);
  import gpio_pkg::*;
  logic in_map;
  assign in_map = mem_addr >= 8'h12 && mem_addr <= 8'h19;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rst; disable iff (1'b0) srst |=> pad_oe == 32'h0 && pad_out == 32'hFFFFFFFF; endproperty
  a_rst: assert property (p_rst) else $error("reset pad state wrong");
  property p_pull; pull_high_en == (~pad_oe & PULL_HIGH_OPT); endproperty
  a_pull: assert property (p_pull) else $error("pull-high mismatch");
  property p_rv; (mem_rd || mem_op != OP_NONE) && in_map |=> mem_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no read answer");
  property p_norv; !mem_rd && mem_op == OP_NONE |=> !mem_rvalid; endproperty
  a_norv: assert property (p_norv) else $error("spurious read answer");
  property p_dir; mem_wr && mem_op == OP_NONE && mem_addr == 8'h13 |=> pad_oe[7:0] == ~$past(mem_wdata); endproperty
  a_dir: assert property (p_dir) else $error("direction write wrong");
  property p_dat; mem_wr && mem_op == OP_NONE && mem_addr == 8'h18 |=> pad_out[31:24] == $past(mem_wdata); endproperty
  a_dat: assert property (p_dat) else $error("latch write wrong");
  property p_hold; !mem_wr && mem_op == OP_NONE |=> $stable(pad_out); endproperty
  a_hold: assert property (p_hold) else $error("latch changed unasked");
  property p_hit; in_map |=> mem_hit; endproperty
  a_hit: assert property (p_hit) else $error("map hit missing");
  property p_ref; mem_rd && !in_map |=> !mem_hit && mem_rdata == 8'h00; endproperty
  a_ref: assert property (p_ref) else $error("unmapped read answered");
endmodule // gpio_checker
bind four_port_bidir_io gpio_checker #(.PULL_HIGH_OPT(PULL_HIGH_OPT)) u_chk (.sys_clk(sys_clk), .srst(srst),
  .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_op(mem_op),
  .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_hit(mem_hit), .pad_out(pad_out), .pad_oe(pad_oe),
  .pull_high_en(pull_high_en));

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import gpio_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, mem_wr = 1'b0, mem_rd = 1'b0, mem_op_to_acc = 1'b0, halt = 1'b0;
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, mem_rdata;
  logic [2:0] mem_bit_sel = 3'h0;
  bit_op_t mem_op = OP_NONE;
  logic mem_rvalid, mem_hit, wake_req;
  logic [31:0] pad_in, pad_out, pad_oe, pull_high_en, src_val = 32'h3C5A96C3, src_en = 32'hFFFFFFFF;
  int err_count = 0, n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  four_port_bidir_io DUT (.sys_clk(sys_clk), .srst(srst), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_wdata(mem_wdata), .mem_op(mem_op), .mem_bit_sel(mem_bit_sel), .mem_op_to_acc(mem_op_to_acc),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_hit(mem_hit), .halt(halt), .wake_req(wake_req),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_high_en(pull_high_en));
  board_model u_board (.pad_out(pad_out), .pad_oe(pad_oe), .pull_high_en(pull_high_en), .src_val(src_val),
    .src_en(src_en), .pad_in(pad_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out;
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One request cycle, answer sampled at the following falling edge
  task automatic xfer(input logic r, input logic w, input bit_op_t op, input logic [7:0] a, input logic [7:0] d,
      input logic [2:0] b, input logic t);
    @(negedge sys_clk);
    {mem_rd, mem_wr, mem_op, mem_addr, mem_wdata, mem_bit_sel, mem_op_to_acc} = {r, w, op, a, d, b, t};
    @(negedge sys_clk);
    {mem_rd, mem_wr, mem_op, mem_op_to_acc} = {1'b0, 1'b0, OP_NONE, 1'b0};
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string m);
    xfer(1'b1, 1'b0, OP_NONE, a, 8'h00, 3'h0, 1'b0);
    chk({24'h0, mem_rdata}, {24'h0, exp}, m);
    chk({31'h0, mem_rvalid}, 32'h1, "read answer");
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) srst = 1'b0;
    // Pad synchroniser needs a few cycles
    repeat (6) @(negedge sys_clk);
    chk(pad_oe, 32'h0, "oe after reset");
    chk(pad_out, 32'hFFFFFFFF, "latch after reset");
    chk(pull_high_en, 32'hFFFFFFFF, "pull after reset");
    for (int p = 0; p < 4; p++) begin
      rd_chk(8'(8'h12 + 2 * p), src_val[8*p+:8], "pad read");
      rd_chk(8'(8'h13 + 2 * p), 8'hFF, "dir reset");
    end
    $display("Test reset state done");
    xfer(1'b0, 1'b1, OP_NONE, 8'h13, 8'h0F, 3'h0, 1'b0);
    xfer(1'b0, 1'b1, OP_NONE, 8'h12, 8'hA5, 3'h0, 1'b0);
    chk(pad_oe[7:0], 8'hF0, "mixed oe");
    rd_chk(8'h12, 8'hA3, "mixed read");
    xfer(1'b0, 1'b1, OP_NONE, 8'h18, 8'h5E, 3'h0, 1'b0);
    xfer(1'b0, 1'b1, OP_NONE, 8'h19, 8'h00, 3'h0, 1'b0);
    chk(pad_out[31:24], 8'h5E, "latch held as input");
    xfer(1'b0, 1'b1, OP_NONE, 8'h13, 8'h00, 3'h0, 1'b0);
    rd_chk(8'h12, 8'hA5, "all output read");
    $display("Test direction done");
    xfer(1'b0, 1'b0, OP_BIT_SET, 8'h12, 8'h00, 3'h6, 1'b0);
    xfer(1'b0, 1'b0, OP_BIT_CLR, 8'h12, 8'h00, 3'h0, 1'b0);
    rd_chk(8'h12, 8'hE4, "set clear");
    xfer(1'b0, 1'b0, OP_CPL, 8'h12, 8'h00, 3'h0, 1'b1);
    chk({24'h0, mem_rdata}, 32'h1B, "cpl to acc");
    rd_chk(8'h12, 8'hE4, "latch kept");
    xfer(1'b0, 1'b0, OP_CPL, 8'h12, 8'h00, 3'h0, 1'b0);
    rd_chk(8'h12, 8'h1B, "cpl to latch");
    // Port B still input: the pad value, not the latch, is modified
    xfer(1'b0, 1'b0, OP_BIT_CLR, 8'h14, 8'h00, 3'h7, 1'b0);
    xfer(1'b0, 1'b1, OP_NONE, 8'h15, 8'h00, 3'h0, 1'b0);
    rd_chk(8'h14, 8'h16, "rmw of inputs");
    $display("Test bit operations done");
    begin : unmapped
      logic [7:0] bad_addr [3] = '{8'h11, 8'h1A, 8'h20};
      foreach (bad_addr[i]) begin
        rd_chk(bad_addr[i], 8'h00, "unmapped read");
        chk({31'h0, mem_hit}, 32'h0, "unmapped hit");
      end
    end
    $display("Test unmapped done");
    xfer(1'b0, 1'b1, OP_NONE, 8'h13, 8'hFF, 3'h0, 1'b0);
    repeat (6) @(negedge sys_clk);
    halt = 1'b1;
    src_val[0] = ~src_val[0];
    begin : wait_wake
      for (int n = 0; n < 12; n++) begin
        @(negedge sys_clk);
        if (wake_req === 1'b1) disable wait_wake;
      end
      chk({31'h0, wake_req}, 32'h1, "no wake");
    end
    n_compared++;
    halt = 1'b0;
    $display("Test wake done");
    close_out();
  end
endmodule // testbench

// file: hw/four_port_bidir_io.sv
// Contract
// - Thirty-two lines as four 8-bit ports, data latches at 12H, 14H, 16H, 18H.
// - Inputs unlatched; read samples pads at the second instruction phase edge.
// - Written output data held until the latch is written again.
// - Per-line direction bit: 1 input, 0 output driven from latch.
// - Direction changeable any time, effective immediately.
// - Input line with pull-high option gets pull-high automatically.
// - Read returns pad for direction 1, latch for direction 0.
// - Set, clear, complement read whole port, modify, write back; complement with mem_op_to_acc writes the result to the core only.
// - Any single latch bit settable or clearable; other latch bits of input lines take the pad level.
// - Outputs always push-pull, never open-drain.
// - Direction registers at 13H, 15H, 17H, 19H.
// - After reset every line is input, pulled high or floating.
// - Every port A line can wake the device from halt.
`timescale 1ns/10ps
module four_port_bidir_io
  import gpio_pkg::*;
#(
  parameter int NPORT = gpio_pkg::NUM_PORTS,
  parameter int PW = gpio_pkg::PORT_W,
  parameter logic [31:0] PULL_HIGH_OPT = 32'hFFFFFFFF,
  parameter logic [7:0] WAKE_OPT = 8'hFF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Core data-memory access
  input wire logic [gpio_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  input wire gpio_pkg::bit_op_t mem_op,
  input wire logic [2:0] mem_bit_sel,
  input wire logic mem_op_to_acc,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid,
  output logic mem_hit,
  // Halt and wake
  input wire logic halt,
  output logic wake_req,
  // Pads
  input wire logic [NPORT*PW-1:0] pad_in,
  output logic [NPORT*PW-1:0] pad_out,
  output logic [NPORT*PW-1:0] pad_oe,
  output logic [NPORT*PW-1:0] pull_high_en
);

  localparam int N = NPORT * PW;

  // ----------------------------------------
  // Pad synchroniser
  // ----------------------------------------
  pad_sync_if #(.W(N)) pads ();
  assign pads.raw = pad_in;

  pad_sync #(.W(N)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pads(pads)
  );

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [PW-1:0] latch_r [NPORT];
  logic [PW-1:0] dir_r [NPORT];
  logic [PW-1:0] latch_nxt [NPORT];
  logic [PW-1:0] dir_nxt [NPORT];
  logic [PW-1:0] port_view [NPORT];
  logic [NPORT-1:0] sel_data;
  logic [NPORT-1:0] sel_dir;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic hit_r;
  logic wake_r;
  logic [N-1:0] pad_out_r;
  logic [N-1:0] pad_oe_r;
  logic [N-1:0] pull_r;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      localparam logic [7:0] DATA_AT = PORT_A_DATA_OFFS + 8'(p) * PORT_STRIDE;
      assign sel_data[p] = (mem_addr == DATA_AT);
      assign sel_dir[p] = (mem_addr == DATA_AT + 8'h01);
      assign port_view[p] = (dir_r[p] & pads.stable[p*PW +: PW]) | (~dir_r[p] & latch_r[p]);
    end
  endgenerate

  wire any_data = |sel_data;
  wire any_dir = |sel_dir;
  wire [PW-1:0] bit_mask = PW'(1) << mem_bit_sel;

  // Read view of the addressed location
  logic [7:0] cur_view;
  always_comb begin
    cur_view = 8'h00;
    for (int i = 0; i < NPORT; i++) begin
      if (sel_data[i])
        cur_view = port_view[i];
      if (sel_dir[i])
        cur_view = dir_r[i];
    end
  end

  logic [7:0] op_result;
  always_comb begin
    unique case (mem_op)
      OP_BIT_SET: op_result = cur_view | bit_mask;
      OP_BIT_CLR: op_result = cur_view & ~bit_mask;
      OP_CPL: op_result = ~cur_view;
      OP_NONE: op_result = mem_wdata;
    endcase
  end

  wire rmw = (mem_op != OP_NONE);
  wire rmw_to_latch = rmw && !(mem_op == OP_CPL && mem_op_to_acc);
  wire do_write = (mem_wr && !rmw) || (rmw && rmw_to_latch);

  // ----------------------------------------
  // Next state of latches
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      latch_nxt[i] = latch_r[i];
      dir_nxt[i] = dir_r[i];
      if (do_write && sel_data[i])
        latch_nxt[i] = op_result;
      if (do_write && sel_dir[i])
        dir_nxt[i] = op_result;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NPORT; i++) begin
      if (srst) begin
        latch_r[i] <= DATA_LATCH_RST;
        dir_r[i] <= DIRECTION_RST;
      end else begin
        latch_r[i] <= latch_nxt[i];
        dir_r[i] <= dir_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Pads are read from the synchroniser's stable value at the read cycle, a few cycles behind the pins, never held between reads
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      rvalid_r <= mem_rd || rmw;
      hit_r <= any_data || any_dir;
      if (rmw && mem_op == OP_CPL && mem_op_to_acc)
        rdata_r <= op_result;
      else if (mem_rd || rmw)
        rdata_r <= cur_view;
    end
  end

  assign mem_rdata = rdata_r;
  assign mem_rvalid = rvalid_r;
  assign mem_hit = hit_r;

  // ----------------------------------------
  // Pad drivers
  // ----------------------------------------
  logic [N-1:0] out_nxt;
  logic [N-1:0] oe_nxt;
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      out_nxt[i*PW +: PW] = latch_nxt[i];
      oe_nxt[i*PW +: PW] = ~dir_nxt[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pad_out_r <= '1;
      pad_oe_r <= '0;
      pull_r <= PULL_HIGH_OPT[N-1:0];
    end else begin
      pad_out_r <= out_nxt;
      pad_oe_r <= oe_nxt;
      pull_r <= ~oe_nxt & PULL_HIGH_OPT[N-1:0];
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign pull_high_en = pull_r;

  // ----------------------------------------
  // Wake from halt
  // ----------------------------------------
  // Only a settled edge on an enabled port A line wakes the core
  always_ff @(posedge sys_clk) begin
    if (srst)
      wake_r <= 1'b0;
    else
      wake_r <= halt && |(pads.changed[PW-1:0] & WAKE_OPT[PW-1:0]);
  end

  assign wake_req = wake_r;

endmodule // four_port_bidir_io

// file: hw/gpio_pkg.sv
package gpio_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;

  // ----------------------------------------
  // Data-memory locations
  // ----------------------------------------
  localparam logic [7:0] PORT_A_DATA_OFFS = 8'h12;
  localparam logic [7:0] PORT_A_DIR_OFFS = 8'h13;
  localparam logic [7:0] PORT_B_DATA_OFFS = 8'h14;
  localparam logic [7:0] PORT_B_DIR_OFFS = 8'h15;
  localparam logic [7:0] PORT_C_DATA_OFFS = 8'h16;
  localparam logic [7:0] PORT_C_DIR_OFFS = 8'h17;
  localparam logic [7:0] PORT_D_DATA_OFFS = 8'h18;
  localparam logic [7:0] PORT_D_DIR_OFFS = 8'h19;
  localparam logic [7:0] PORT_STRIDE = 8'h02;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DATA_LATCH_RST = 8'hFF;
  localparam logic [7:0] DIRECTION_RST = 8'hFF;

  // ----------------------------------------
  // Bit operations of the core
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_NONE,
    OP_BIT_SET,
    OP_BIT_CLR,
    OP_CPL
  } bit_op_t;

endpackage

// file: hw/pad_sync.sv
`timescale 1ns/10ps
module pad_sync #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Pad levels
  pad_sync_if.sync pads
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] stable_r;
  logic [W-1:0] agree;

  // Second and third stage must agree before a change counts
  assign agree = ~(s2_r ^ s3_r);
  assign pads.stable = stable_r;
  assign pads.changed = agree & (s2_r ^ stable_r);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      stable_r <= '1;
    end else begin
      s1_r <= pads.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stable_r <= (agree & s2_r) | (~agree & stable_r);
    end
  end

endmodule // pad_sync

// file: hw/pad_sync_if.sv
`timescale 1ns/10ps
interface pad_sync_if #(parameter int W = 32);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  logic [W-1:0] changed;
  modport owner (output raw, input stable, input changed);
  modport sync (input raw, output stable, output changed);
endinterface : pad_sync_if
